// >>> design/dbs_link_if.sv
// Pin-level link between the memory controller and the SRAM device
`timescale 1ns/10ps
`default_nettype none
interface dbs_link_if;
  import dbs_pkg::*;
  logic       k;
  logic       k_n;
  logic       load_strobe_n;
  logic       rd_wr_sel;
  dbs_addr_t  sync_address_in;
  dbs_lane_t  byte_lane_write_n;
  logic       dll_enable;
  dbs_word_t  dq_ctl_o;
  logic       dq_ctl_oe;
  dbs_word_t  dq_dev_o;
  logic       dq_dev_oe;
  dbs_word_t  dq;
  logic       echo_clock_out;
  logic       echo_clock_out_n;
  logic       read_valid_flag;

  // Resolved bus level; an undriven bus reads as zero
  assign dq = dq_ctl_oe ? dq_ctl_o : (dq_dev_oe ? dq_dev_o : '0);

  modport ctrl (
    output k, k_n, load_strobe_n, rd_wr_sel, sync_address_in,
    output byte_lane_write_n, dll_enable, dq_ctl_o, dq_ctl_oe,
    input  dq, echo_clock_out, echo_clock_out_n, read_valid_flag
  );
  modport dev (
    input  k, k_n, load_strobe_n, rd_wr_sel, sync_address_in,
    input  byte_lane_write_n, dll_enable, dq,
    output dq_dev_o, dq_dev_oe, echo_clock_out, echo_clock_out_n,
    output read_valid_flag
  );
endinterface
`default_nettype wire

// >>> design/dbs_mem_ctrl.sv
// Memory controller end: makes the link clocks, issues bursts, collects reads
`timescale 1ns/10ps
`default_nettype none
module dbs_mem_ctrl (
  dbs_link_if.ctrl              link,
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             REQ_VALID,
  output logic                  REQ_READY,
  input  wire logic             REQ_WRITE,
  input  wire dbs_pkg::dbs_addr_t  REQ_ADDR,
  input  wire dbs_pkg::dbs_burst_t REQ_WDATA,
  input  wire dbs_pkg::dbs_bwn_t   REQ_BW_N,
  input  wire logic             DLL_ENABLE,
  output logic                  RD_VALID,
  output dbs_pkg::dbs_burst_t   RD_DATA
);
  import dbs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          ph;
    logic                k;
    logic                kn;
    logic                ld_n;
    logic                rw;
    dbs_addr_t           addr;
    dbs_lane_t           bw_n;
    dbs_word_t           dq_o;
    logic                dq_oe;
    logic                dll;
    logic [1:0]          nxt_any;
    logic [1:0]          nxt_wr;
    logic [WR_SLOTS-1:0] ws;
    dbs_burst_t          wnext;
    dbs_bwn_t            bnext;
    dbs_burst_t          wcur;
    dbs_bwn_t            bcur;
    logic [1:0]          rcnt;
    dbs_burst_t          rsh;
    logic                rd_valid;
    dbs_burst_t          rd_data;
  } dbs_ctrl_t;

  dbs_ctrl_t h_q;
  dbs_ctrl_t h_d;
  logic      vld_s;
  dbs_word_t dq_s;
  logic      tick;
  logic      issue;

  // Each read beat sits one K half-period, two CLK cycles, so a plain two-stage sample is safe
  dbs_sync2 #(
    .W (DATA_W + 1)
  ) u_rd_sync (
    .CLK (CLK),
    .RST (RST),
    .D   ({link.read_valid_flag, link.dq}),
    .Q   ({vld_s, dq_s})
  );

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  assign tick      = (h_q.ph == PH_ISSUE);
  // Writes wait longer after a read so the bus turns round cleanly
  assign REQ_READY = tick && (h_q.nxt_any == 2'h0)
                     && (!REQ_WRITE || (h_q.nxt_wr == 2'h0));
  assign issue     = REQ_VALID && REQ_READY;

  always_comb begin
    h_d          = h_q;
    h_d.ph       = h_q.ph + 2'h1;
    h_d.k        = !h_d.ph[1];
    h_d.kn       = h_d.ph[1];
    h_d.rd_valid = 1'b0;
    h_d.dll      = DLL_ENABLE || !DLL_OFF_OK;
    if (tick) begin
      if (h_q.nxt_any != 2'h0) begin
        h_d.nxt_any = h_q.nxt_any - 2'h1;
      end
      if (h_q.nxt_wr != 2'h0) begin
        h_d.nxt_wr = h_q.nxt_wr - 2'h1;
      end
      if (issue) begin
        h_d.ld_n    = 1'b0;
        h_d.rw      = !REQ_WRITE;
        h_d.addr    = REQ_ADDR;
        h_d.nxt_any = CMD_GAP;
        h_d.nxt_wr  = REQ_WRITE ? CMD_GAP : RD_WR_GAP;
        if (REQ_WRITE) begin
          h_d.wnext = REQ_WDATA;
          h_d.bnext = REQ_BW_N;
        end
      end
    end
    // Command stands across exactly one K rise
    if (h_q.ph == PH_RISE) begin
      h_d.ld_n = 1'b1;
    end
    // Write beats change midway between K and K# edges
    if (!h_q.ph[0]) begin
      h_d.ws   = {h_q.ws[WR_SLOTS-2:0], issue && REQ_WRITE};
      h_d.bw_n = '1;
      if (h_d.ws[2]) begin
        h_d.wcur = h_q.wnext;
        h_d.bcur = h_q.bnext;
        h_d.dq_o = h_q.wnext[0 +: DATA_W];
        h_d.bw_n = h_q.bnext[0 +: LANES];
      end
      for (int b = 1; b < BURST; b++) begin
        if (h_d.ws[b+2]) begin
          h_d.dq_o = h_q.wcur[b*DATA_W +: DATA_W];
          h_d.bw_n = h_q.bcur[b*LANES +: LANES];
        end
      end
      h_d.dq_oe = |h_d.ws[WR_SLOTS-1:2];
    end
    // ----------------------------------------------------------------
    // Read collection, first beat lands lowest
    // ----------------------------------------------------------------
    if (h_q.ph[0] && vld_s) begin
      h_d.rsh  = {dq_s, h_q.rsh[BURST_W-1:DATA_W]};
      h_d.rcnt = h_q.rcnt + 2'h1;
      if (h_q.rcnt == LAST_BEAT) begin
        h_d.rd_valid = 1'b1;
        h_d.rd_data  = h_d.rsh;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      h_q      <= '0;
      // Start one step short of a rise so the first K high is full width
      h_q.ph   <= PH_RISE - 2'h1;
      h_q.kn   <= 1'b1;
      h_q.ld_n <= 1'b1;
      h_q.bw_n <= '1;
      h_q.dll  <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins and user outputs
  // ----------------------------------------------------------------
  assign link.k                 = h_q.k;
  assign link.k_n               = h_q.kn;
  assign link.load_strobe_n     = h_q.ld_n;
  assign link.rd_wr_sel         = h_q.rw;
  assign link.sync_address_in   = h_q.addr;
  assign link.byte_lane_write_n = h_q.bw_n;
  assign link.dll_enable        = h_q.dll;
  assign link.dq_ctl_o          = h_q.dq_o;
  assign link.dq_ctl_oe         = h_q.dq_oe;
  assign RD_VALID               = h_q.rd_valid;
  assign RD_DATA                = h_q.rd_data;
endmodule
`default_nettype wire

// >>> design/dbs_pkg.sv
// Shared constants, types and helpers for the burst-of-four DDR SRAM link
package dbs_pkg;
  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int DATA_W  = 36;
  localparam int LANE_W  = 9;
  localparam int LANES   = 4;
  localparam int BURST   = 4;
  localparam int ADDR_W  = 19;
  localparam int WADDR_W = 21;
  localparam int DEPTH   = 2097152;
  localparam int BURST_W = BURST * DATA_W;
  localparam int BWN_W   = BURST * LANES;
  localparam int WR_SLOTS = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int K_DIV           = 4;
  localparam int K_MHZ           = CLK_MHZ / K_DIV;
  localparam int DLL_OFF_MAX_MHZ = 167;
  localparam bit DLL_OFF_OK      = (K_MHZ <= DLL_OFF_MAX_MHZ);
  localparam logic [4:0] DLL_LOCK_CYC = 5'h10;
  localparam int FETCH_DLL_ON    = 1;
  localparam int FETCH_DLL_OFF   = 0;
  localparam logic [1:0] CMD_GAP    = 2'h1;
  localparam logic [1:0] RD_WR_GAP  = 2'h3;
  localparam logic [1:0] PH_RISE    = 2'h0;
  localparam logic [1:0] PH_ISSUE   = 2'h2;
  localparam logic [1:0] LAST_BEAT  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [DATA_W-1:0]  dbs_word_t;
  typedef logic [LANES-1:0]   dbs_lane_t;
  typedef logic [ADDR_W-1:0]  dbs_addr_t;
  typedef logic [BURST_W-1:0] dbs_burst_t;
  typedef logic [BWN_W-1:0]   dbs_bwn_t;

  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_B01  = 4'h2,
    RD_B23  = 4'h4,
    RD_TAIL = 4'h8
  } dbs_rd_st_t;

  // Lanes whose strobe is high keep the old contents
  function automatic dbs_word_t lane_merge(input dbs_word_t old_w,
                                           input dbs_word_t new_w,
                                           input dbs_lane_t bw_n);
    dbs_word_t res;
    res = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (!bw_n[l]) begin
        res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction
endpackage

// >>> design/dbs_sram_dev.sv
// Burst-of-four DDR common-I/O SRAM device end
`timescale 1ns/10ps
`default_nettype none
module dbs_sram_dev (
  dbs_link_if.dev   link,
  input  wire logic RST,
  output logic      DLL_ACTIVE
);
  import dbs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]             wr_pipe;
    logic [2:0]             rd_pipe;
    dbs_addr_t              wa_cmd;
    dbs_addr_t              wa_com;
    dbs_addr_t              ra;
    dbs_word_t              wd0;
    dbs_word_t              wd2;
    dbs_lane_t              bw0;
    dbs_lane_t              bw2;
    dbs_word_t [BURST-1:0]  rbuf;
    dbs_rd_st_t             st;
    dbs_word_t              q;
    logic                   vld;
    logic [4:0]             lock_cnt;
    logic                   dll_on;
  } dbs_rise_t;

  typedef struct packed {
    dbs_word_t wd1;
    dbs_word_t wd3;
    dbs_lane_t bw1;
    dbs_lane_t bw3;
    dbs_word_t q;
    logic      vld;
  } dbs_fall_t;

  dbs_rise_t r_q;
  dbs_rise_t r_d;
  dbs_fall_t f_q;
  dbs_fall_t f_d;
  dbs_word_t mem_q [DEPTH];
  dbs_word_t com_data [BURST];
  dbs_lane_t com_bw [BURST];
  logic      dll_pin_s;
  logic      cmd_rd;
  logic      cmd_wr;
  logic      fetch;
  logic      hit;

  // DLL enable pin is asynchronous to the link clock
  dbs_sync2 #(
    .W (1)
  ) u_dll_sync (
    .CLK (link.k),
    .RST (RST),
    .D   (link.dll_enable),
    .Q   (dll_pin_s)
  );

  // ----------------------------------------------------------------
  // Command decode and write assembly
  // ----------------------------------------------------------------
  assign cmd_rd = !link.load_strobe_n && link.rd_wr_sel;
  assign cmd_wr = !link.load_strobe_n && !link.rd_wr_sel;

  // Beats one and three come from primary edges, two and four from the other
  assign com_data[0] = r_q.wd0;
  assign com_data[1] = f_q.wd1;
  assign com_data[2] = r_q.wd2;
  assign com_data[3] = f_q.wd3;
  assign com_bw[0]   = r_q.bw0;
  assign com_bw[1]   = f_q.bw1;
  assign com_bw[2]   = r_q.bw2;
  assign com_bw[3]   = f_q.bw3;

  // Fetch happens later with the DLL locked, earlier in bypass mode
  assign fetch = r_q.dll_on ? r_q.rd_pipe[FETCH_DLL_ON]
                            : r_q.rd_pipe[FETCH_DLL_OFF];
  // In bypass mode a fetch can meet the commit of the write before it
  assign hit = r_q.wr_pipe[2] && (r_q.wa_com == r_q.ra);

  // ----------------------------------------------------------------
  // Primary-edge logic
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.wr_pipe = {r_q.wr_pipe[1:0], cmd_wr};
    r_d.rd_pipe = {r_q.rd_pipe[1:0], cmd_rd};
    if (cmd_wr) begin
      r_d.wa_cmd = link.sync_address_in;
    end
    if (cmd_rd) begin
      r_d.ra = link.sync_address_in;
    end
    if (r_q.wr_pipe[0]) begin
      r_d.wd0 = link.dq;
      r_d.bw0 = link.byte_lane_write_n;
    end
    if (r_q.wr_pipe[1]) begin
      r_d.wd2    = link.dq;
      r_d.bw2    = link.byte_lane_write_n;
      r_d.wa_com = r_q.wa_cmd;
    end
    if (!dll_pin_s) begin
      r_d.lock_cnt = 5'h00;
      r_d.dll_on   = 1'b0;
    end else if (r_q.lock_cnt != DLL_LOCK_CYC) begin
      r_d.lock_cnt = r_q.lock_cnt + 5'h01;
    end else begin
      r_d.dll_on = 1'b1;
    end
    case (r_q.st)
      RD_B01: begin
        r_d.q   = r_q.rbuf[1];
        r_d.vld = 1'b1;
        r_d.st  = RD_B23;
      end
      RD_B23: begin
        r_d.q   = r_q.rbuf[3];
        r_d.vld = 1'b1;
        r_d.st  = RD_TAIL;
      end
      RD_TAIL: begin
        r_d.vld = 1'b0;
        r_d.st  = RD_IDLE;
      end
      RD_IDLE: begin
        r_d.vld = 1'b0;
      end
      default: begin
        r_d.vld = 1'b0;
        r_d.st  = RD_IDLE;
      end
    endcase
    // A fresh fetch restarts the sequence so reads may run back to back
    if (fetch) begin
      r_d.st = RD_B01;
      for (int b = 0; b < BURST; b++) begin
        r_d.rbuf[b] = hit ? lane_merge(mem_q[{r_q.ra, 2'(b)}],
                                       com_data[b], com_bw[b])
                          : mem_q[{r_q.ra, 2'(b)}];
      end
    end
  end

  always_ff @(posedge link.k or posedge RST) begin
    if (RST) begin
      r_q    <= '0;
      r_q.st <= RD_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  // Buffered write lands three cycles after its command, after beat four
  always_ff @(posedge link.k) begin
    if (r_q.wr_pipe[2]) begin
      for (int b = 0; b < BURST; b++) begin
        mem_q[{r_q.wa_com, 2'(b)}] <=
          lane_merge(mem_q[{r_q.wa_com, 2'(b)}], com_data[b], com_bw[b]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Complementary-edge logic
  // ----------------------------------------------------------------
  always_comb begin
    f_d = f_q;
    if (r_q.wr_pipe[1]) begin
      f_d.wd1 = link.dq;
      f_d.bw1 = link.byte_lane_write_n;
    end
    if (r_q.wr_pipe[2]) begin
      f_d.wd3 = link.dq;
      f_d.bw3 = link.byte_lane_write_n;
    end
    case (r_q.st)
      RD_B01: begin
        f_d.q   = r_q.rbuf[0];
        f_d.vld = 1'b1;
      end
      RD_B23: begin
        f_d.q   = r_q.rbuf[2];
        f_d.vld = 1'b1;
      end
      default: begin
        f_d.vld = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link.k_n or posedge RST) begin
    if (RST) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Each half cycle shows the register launched on its own edge
  assign link.dq_dev_o         = link.k ? r_q.q : f_q.q;
  assign link.read_valid_flag  = link.k ? r_q.vld : f_q.vld;
  assign link.dq_dev_oe        = link.read_valid_flag;
  // Echo pair follows the input clocks and never stops with the bus
  assign link.echo_clock_out   = link.k;
  assign link.echo_clock_out_n = link.k_n;
  assign DLL_ACTIVE            = r_q.dll_on;
endmodule
`default_nettype wire

// >>> design/dbs_sync2.sv
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/10ps
`default_nettype none
module dbs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= '0;
      Q      <= '0;
    end else begin
      meta_q <= D;
      Q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dbs_link_asserts.sv
// Link-level assertions for the burst-of-four SRAM link
`timescale 1ns/10ps
`default_nettype none
module dbs_link_asserts (
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic               k,
  input wire logic               k_n,
  input wire logic               load_strobe_n,
  input wire logic               rd_wr_sel,
  input wire dbs_pkg::dbs_lane_t byte_lane_write_n,
  input wire logic               dll_enable,
  input wire logic               dq_ctl_oe,
  input wire logic               dq_dev_oe,
  input wire logic               echo_clock_out,
  input wire logic               echo_clock_out_n,
  input wire logic               read_valid_flag
);
  import dbs_pkg::*;
  // ----------------------------------------------------------------
  // Commands as the device sees them at a k rise
  // ----------------------------------------------------------------
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence cmd_s;
    $rose(k) && !$past(load_strobe_n);
  endsequence
  sequence rd_cmd_s;
    $rose(k) && !$past(load_strobe_n) && $past(rd_wr_sel);
  endsequence
  sequence wr_cmd_s;
    $rose(k) && !$past(load_strobe_n) && !$past(rd_wr_sel);
  endsequence
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  k_pair_a: assert property (k_n != k) else $error("k_n not complement of k");
  k_shape_a: assert property ($rose(k) |-> k ##1 k ##1 !k ##1 !k ##1 k)
    else $error("k period wrong");
  echo_pair_a: assert property (echo_clock_out != echo_clock_out_n)
    else $error("echo clocks not complementary");
  echo_run_a: assert property ($rose(echo_clock_out) |-> ##4 $rose(echo_clock_out))
    else $error("echo clock stopped");
  cmd_space_a: assert property (cmd_s |-> ##4 ($rose(k) && $past(load_strobe_n)))
    else $error("commands on adjacent k rises");
  rd_lat_on_a: assert property (rd_cmd_s ##0 dll_enable |-> ##[9:10] read_valid_flag[*8])
    else $error("read beats late with DLL on");
  rd_lat_off_a: assert property (rd_cmd_s ##0 !dll_enable |-> ##[5:6] read_valid_flag[*8])
    else $error("read beats late with DLL off");
  wr_beats_a: assert property (wr_cmd_s |-> ##[2:3] dq_ctl_oe[*8])
    else $error("write beats not driven");
  bus_clash_a: assert property (!(dq_ctl_oe && dq_dev_oe))
    else $error("both ends drive the bus");
  dev_flag_a: assert property ($rose(read_valid_flag) |-> read_valid_flag[*8])
    else $error("valid flag shorter than a burst");
  idle_lanes_a: assert property (!dq_ctl_oe |-> byte_lane_write_n == 4'hf)
    else $error("lane strobes active outside write");
  cover property (rd_cmd_s ##0 dll_enable);
  cover property (rd_cmd_s ##0 !dll_enable);
  cover property (wr_cmd_s);
endmodule
`default_nettype wire

// >>> testbench/ddr_burst4_common_io_sram_port_test.sv
// Bench joining the controller and device ends across the link
`timescale 1ns/10ps
`default_nettype none
module ddr_burst4_common_io_sram_port_test;
  import dbs_pkg::*;
  logic       clk;
  logic       rst;
  logic       req_valid;
  logic       req_ready;
  logic       req_write;
  dbs_addr_t  req_addr;
  dbs_burst_t req_wdata;
  dbs_bwn_t   req_bw_n;
  logic       dll_en;
  logic       rd_valid;
  dbs_burst_t rd_data;
  logic       dll_active;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cyc = 0;
  dbs_word_t  mem [int];

  // Accept edge to result pulse in CLK cycles: one to the K rise, 2.5 K
  // periods to the first beat, three half periods more, then the sampler
  localparam int RD_LAT_ON  = 1 + (5 * K_DIV) / 2 + 3 * (K_DIV / 2) + 4;
  // Bypass mode delivers one K period sooner
  localparam int RD_LAT_OFF = RD_LAT_ON - K_DIV;

  dbs_link_if link ();
  dbs_mem_ctrl i_dbs_mem_ctrl (.link(link.ctrl), .CLK(clk), .RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_BW_N(req_bw_n), .DLL_ENABLE(dll_en), .RD_VALID(rd_valid), .RD_DATA(rd_data));
  dbs_sram_dev i_dbs_sram_dev (.link(link.dev), .RST(rst), .DLL_ACTIVE(dll_active));
  dbs_link_asserts i_dbs_link_asserts (.CLK(clk), .RST(rst), .k(link.k), .k_n(link.k_n),
    .load_strobe_n(link.load_strobe_n), .rd_wr_sel(link.rd_wr_sel),
    .byte_lane_write_n(link.byte_lane_write_n), .dll_enable(link.dll_enable),
    .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe),
    .echo_clock_out(link.echo_clock_out), .echo_clock_out_n(link.echo_clock_out_n),
    .read_valid_flag(link.read_valid_flag));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Entered just after a falling edge; returns the cycle of the accepting edge
  task automatic issue(input logic wr, input dbs_addr_t a, input logic [7:0] s,
                       input dbs_bwn_t bw, output int t);
    int n;
    n = 0;
    // Let an edge pass so a released request is never raised again at once
    @(negedge clk);
    req_write = wr;
    req_addr = a;
    req_bw_n = bw;
    for (int b = 0; b < BURST; b++) begin
      req_wdata[b*DATA_W +: DATA_W] = {s, a, 9'(b)};
      for (int l = 0; l < LANES; l++) begin
        if (wr && !bw[b*LANES+l]) begin
          mem[int'(a)*4+b][l*LANE_W +: LANE_W] = req_wdata[b*DATA_W+l*LANE_W +: LANE_W];
        end
      end
    end
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(144'(req_ready), 144'h1);
    @(negedge clk);
    t = cyc;
    req_valid = 1'b0;
  endtask

  task automatic collect(input dbs_addr_t a, input int t, input int lat);
    int n;
    dbs_burst_t e;
    n = 0;
    while (rd_valid !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    for (int b = 0; b < BURST; b++) begin
      e[b*DATA_W +: DATA_W] = mem[int'(a)*4+b];
    end
    check(rd_data, e);
    check(144'(cyc - t), 144'(lat));
    @(negedge clk);
  endtask

  task automatic wait_lock;
    int n;
    n = 0;
    while (dll_active !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(144'(dll_active), 144'h1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Read straight after the write: with the DLL on, the write commits before the fetch
  task automatic sc_bursts;
    int t;
    dbs_addr_t a [3] = '{19'h00000, 19'h2aaaa, 19'h7ffff};
    foreach (a[i]) begin
      issue(1'b1, a[i], 8'h10 + 8'(i), 16'h0000, t);
      issue(1'b0, a[i], 8'h00, 16'hffff, t);
      collect(a[i], t, RD_LAT_ON);
    end
  endtask

  task automatic sc_lanes;
    int t;
    issue(1'b1, 19'h00123, 8'h21, 16'h0000, t);
    issue(1'b1, 19'h00123, 8'h42, 16'h5a3c, t);
    issue(1'b0, 19'h00123, 8'h00, 16'hffff, t);
    collect(19'h00123, t, RD_LAT_ON);
  endtask

  task automatic sc_back2back;
    int t1;
    int t2;
    issue(1'b0, 19'h00000, 8'h00, 16'hffff, t1);
    issue(1'b0, 19'h7ffff, 8'h00, 16'hffff, t2);
    collect(19'h00000, t1, RD_LAT_ON);
    collect(19'h7ffff, t2, RD_LAT_ON);
  endtask

  task automatic sc_dll_off;
    int t;
    dll_en = 1'b0;
    repeat (40) @(negedge clk);
    check(144'(dll_active), 144'h0);
    // In bypass mode this read is fetched on the edge the write commits
    issue(1'b1, 19'h2aaaa, 8'h33, 16'h0f00, t);
    issue(1'b0, 19'h2aaaa, 8'h00, 16'hffff, t);
    collect(19'h2aaaa, t, RD_LAT_OFF);
    dll_en = 1'b1;
    wait_lock;
    issue(1'b0, 19'h00123, 8'h00, 16'hffff, t);
    collect(19'h00123, t, RD_LAT_ON);
  endtask

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_bw_n = '1;
    dll_en = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    wait_lock;
    sc_bursts;
    sc_lanes;
    sc_back2back;
    sc_dll_off;
    print_verdict;
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
